// file: rtl/scsi_status_irq.sv
/*
 * scsi_status_irq: status flags, latched interrupt flags and enables of a smart card
 * interface, with its control, contact and selection registers, over APB.
 * Assumes UART and waiting time counter events are single-cycle pulses
 * on pclk; card presence and supply-in-range come from pins and are synchronised here.
 */
// Notes on behaviour
// R01: buffer-empty sets on transfer, clears on buffer write
// R02: software trusts buffer-empty only for short guard
// R03: card present status follows pin, no debounce
// R04: presence rise requests irq when enabled
// R05: reserved bits read zero
// R06: supply good follows in-range monitor
// R07: contact bits change only when supply good; bits 7 and 0 change regardless
// R08: timeout sets on expiry, clears on reload/reset
// R09: tx done only on successful transmission; without repetition a failed send sets it too
// R10: rx done set, also after final failure
// R11: parity error only on final failed repetition
// R12: buffer-empty irq flag latched until cleared
// R13: supply error flag latched on leaving range
// R14: timeout irq flag latched until cleared
// R15: tx done irq flag latched until cleared
// R16: rx done irq flag latched until cleared
// R17: parity irq flag set with tx/rx flag
// R18: enable bits at 7,6,4,3,2,1
// R19: enable bit 0 gates parity irq
// R20: repeat select chooses five or four sends
// R21: one irq line from flag and enable
`timescale 1ns/1ps
module scsi_status_irq
	import scsi_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [SCSI_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic card_detect_pin,
	input wire logic supply_in_range_pin,
	input wire logic tx_buffer_moved,
	input wire logic tx_char_ok,
	input wire logic tx_char_failed,
	input wire logic rx_char_ok,
	input wire logic rx_char_failed,
	input wire logic wait_expired,
	input wire logic wait_reload,
	input wire logic [7:0] rx_byte,
	output logic [7:0] tx_byte,
	output logic tx_byte_load,
	output logic [7:0] contact_levels,
	output logic [7:0] control_bits,
	output logic [2:0] repeat_total,
	output logic irq
);
	logic [1:0] card_sync_reg;
	logic [1:0] vok_sync_reg;
	logic card_present_status;
	logic supply_in_range_status;
	logic card_prev_reg;
	logic vok_prev_reg;
	logic tx_buffer_empty_status;
	logic wait_timeout_status;
	logic tx_char_done_status;
	logic rx_char_done_status;
	logic parity_error_status;
	logic [7:0] ident_reg;
	logic card_irq_reg;
	logic [7:0] enable_reg;
	logic [7:0] control_reg;
	logic [7:0] contact_reg;
	logic [7:0] select_reg;
	logic [7:0] tx_rx_byte_buffer;
	logic [7:0] status_rd;
	logic [7:0] rd_next;
	logic [7:0] idx;
	logic access;
	logic wr;
	logic rd;
	logic mapped;
	logic [7:0] wbyte;
	logic wr_en;
	logic wr_status;
	logic wr_buffer;
	logic rep_on;
	logic tx_done_ev;
	logic tx_irq_ev;
	logic rx_done_ev;
	logic par_ev;
	logic card_rise;
	logic vok_fall;

	// apb decode; zero wait states, unmapped words read zero with pslverr
	assign idx = paddr[SCSI_IDX_LSB +: 8];
	assign access = psel && penable;
	assign wr = access && pwrite && pstrb[0];
	assign rd = access && !pwrite;
	assign mapped = (idx == SCSI_IDX_SELECT) || (idx == SCSI_IDX_ENABLE) ||
		(idx == SCSI_IDX_IDENT) || (idx == SCSI_IDX_STATUS) ||
		(idx == SCSI_IDX_CONTACT) || (idx == SCSI_IDX_CONTROL) ||
		(idx == SCSI_IDX_BUFFER);
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	assign wbyte = pwdata[7:0];
	assign wr_en = wr && (idx == SCSI_IDX_ENABLE);
	assign wr_status = wr && (idx == SCSI_IDX_STATUS);
	assign wr_buffer = wr && (idx == SCSI_IDX_BUFFER);

	// pins pass two flops; only stage two is looked at
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			card_sync_reg <= 2'h3; // idle level of an open detector, so no false rise after reset
			vok_sync_reg <= 2'h0;
		end else begin
			card_sync_reg <= {card_sync_reg[0], card_detect_pin};
			vok_sync_reg <= {vok_sync_reg[0], supply_in_range_pin};
		end
	end

	// detector sense bit turns the raw pin into presence; no debounce (software filters)
	assign card_present_status = card_sync_reg[1] ^ ~control_reg[SCSI_B_CARDDET]; // see R03
	assign supply_in_range_status = vok_sync_reg[1]; // see R06

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			card_prev_reg <= 1'b0;
			vok_prev_reg <= 1'b0;
		end else begin
			card_prev_reg <= card_present_status;
			vok_prev_reg <= supply_in_range_status;
		end
	end
	assign card_rise = card_present_status && !card_prev_reg; // see R04
	assign vok_fall = !supply_in_range_status && vok_prev_reg; // see R13

	// repetition filtering of uart outcomes
	assign rep_on = control_reg[SCSI_B_CREP];
	// with repetition a failed final send is no success; without it the byte still went out
	assign tx_done_ev = tx_char_ok || (!rep_on && tx_char_failed); // see R09
	// the transmit flag marks any finished send, so the parity flag always has a partner
	assign tx_irq_ev = tx_char_ok || tx_char_failed; // see R15 R17
	// a failed character is still a received one, so the bad byte can be read
	assign rx_done_ev = rx_char_ok || rx_char_failed; // see R10
	// without repetition the transmitter never hears the card's error signal
	assign par_ev = rx_char_failed || (rep_on && tx_char_failed); // see R11
	assign repeat_total = select_reg[SCSI_B_REPSEL] ? SCSI_REP_SHORT : SCSI_REP_NORMAL; // see R20

	// buffer-empty: transfer set wins over a same-cycle buffer write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_buffer_empty_status <= SCSI_STATUS_RESET[SCSI_B_TBE];
		end else if (tx_buffer_moved) begin
			tx_buffer_empty_status <= 1'b1; // see R01
		end else if (wr_buffer) begin
			tx_buffer_empty_status <= 1'b0; // see R01
		end
	end

	// timeout status: cleared only by reload, expiry wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_timeout_status <= 1'b0;
		end else if (wait_expired) begin
			wait_timeout_status <= 1'b1; // see R08
		end else if (wait_reload) begin
			wait_timeout_status <= 1'b0; // see R08
		end
	end

	// software-cleared status bits: write zero clears, a same-cycle event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_char_done_status <= 1'b0;
			rx_char_done_status <= 1'b0;
			parity_error_status <= 1'b0;
		end else begin
			tx_char_done_status <= tx_done_ev ||
				(tx_char_done_status && !(wr_status && !wbyte[SCSI_B_TC])); // see R09
			rx_char_done_status <= rx_done_ev ||
				(rx_char_done_status && !(wr_status && !wbyte[SCSI_B_RC])); // see R10
			parity_error_status <= par_ev ||
				(parity_error_status && !(wr_status && !wbyte[SCSI_B_PE])); // see R11
		end
	end

	// latched interrupt flags; read-only, so software clears by writing ones (w1c)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ident_reg <= SCSI_ZERO8;
		end else begin
			ident_reg <= (ident_reg & ~({8{wr && idx == SCSI_IDX_IDENT}} & wbyte)
				& SCSI_IDENT_MASK) |
				{tx_buffer_moved, 2'b00, vok_fall, wait_expired,
				tx_irq_ev, rx_done_ev, par_ev}; // see R12 R13 R14 R15 R16 R17
		end
	end

	// presence rise pending flag; cleared by writing one to bit 6 of the ident word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			card_irq_reg <= 1'b0;
		end else if (card_rise) begin
			card_irq_reg <= 1'b1; // see R04
		end else if (wr && idx == SCSI_IDX_IDENT && wbyte[SCSI_B_CARD]) begin
			card_irq_reg <= 1'b0;
		end
	end

	// enable register, reserved bit 5 held zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_reg <= SCSI_ZERO8;
		end else if (wr_en) begin
			enable_reg <= wbyte & SCSI_ENABLE_MASK; // see R18 R19 R05
		end
	end

	// control and selection registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_reg <= SCSI_ZERO8;
			select_reg <= SCSI_ZERO8;
		end else begin
			if (wr && idx == SCSI_IDX_CONTROL) begin
				control_reg <= wbyte;
			end
			if (wr && idx == SCSI_IDX_SELECT) begin
				select_reg <= wbyte & SCSI_SELECT_MASK;
			end
		end
	end

	// contact bits guarded by supply good; bits 7 and 0 always writable, bit 6 held zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			contact_reg <= SCSI_ZERO8;
		end else if (wr && idx == SCSI_IDX_CONTACT) begin
			if (supply_in_range_status) begin
				contact_reg <= wbyte & SCSI_CONTACT_RW; // see R07
			end else begin
				contact_reg <= (contact_reg & SCSI_CONTACT_GUARDED) |
					(wbyte & SCSI_CONTACT_RW & ~SCSI_CONTACT_GUARDED); // see R07
			end
		end
	end

	// byte buffer: a write goes to the uart, a finished reception overwrites
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_rx_byte_buffer <= SCSI_ZERO8;
		end else if (wr_buffer) begin
			tx_rx_byte_buffer <= wbyte;
		end else if (rx_done_ev) begin
			tx_rx_byte_buffer <= rx_byte;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_byte <= SCSI_ZERO8;
			tx_byte_load <= 1'b0;
		end else begin
			tx_byte_load <= wr_buffer;
			if (wr_buffer) begin
				tx_byte <= wbyte;
			end
		end
	end

	assign contact_levels = contact_reg;
	assign control_bits = control_reg;

	// one line for every enabled flag, presence at bit 6
	assign irq = |((ident_reg | {1'b0, card_irq_reg, 6'h00}) & enable_reg); // see R21 R04 R19

	assign status_rd = {tx_buffer_empty_status, card_present_status, 1'b0,
		supply_in_range_status, wait_timeout_status, tx_char_done_status,
		rx_char_done_status, parity_error_status}; // see R05

	// read mux; reserved bits come back zero
	always_comb begin
		rd_next = SCSI_ZERO8;
		unique case (idx)
			SCSI_IDX_SELECT: rd_next = select_reg;
			SCSI_IDX_ENABLE: rd_next = enable_reg;
			SCSI_IDX_IDENT: rd_next = ident_reg & SCSI_IDENT_MASK; // see R05
			SCSI_IDX_STATUS: rd_next = status_rd;
			SCSI_IDX_CONTACT: rd_next = contact_reg;
			SCSI_IDX_CONTROL: rd_next = control_reg;
			SCSI_IDX_BUFFER: rd_next = tx_rx_byte_buffer;
			default: rd_next = SCSI_ZERO8;
		endcase
	end
	assign prdata = rd ? {24'h000000, rd_next} : 32'h00000000;

	// assertions
	a_tbe_set: assert property (@(posedge pclk) disable iff (!presetn) // see R01
		tx_buffer_moved |=> tx_buffer_empty_status)
		else $error("buffer empty not set after transfer");
	a_tbe_clear: assert property (@(posedge pclk) disable iff (!presetn) // see R01
		wr_buffer && !tx_buffer_moved |=> !tx_buffer_empty_status)
		else $error("buffer empty not cleared by write");
	a_wto_hold: assert property (@(posedge pclk) disable iff (!presetn) // see R08
		wait_timeout_status && !wait_reload |=> wait_timeout_status)
		else $error("timeout status lost without reload");
	a_tc_fail: assert property (@(posedge pclk) disable iff (!presetn) // see R09
		!tx_char_done_status && !tx_char_ok && (rep_on || !tx_char_failed)
		|=> !tx_char_done_status)
		else $error("tx done set without success");
	a_pi_pair: assert property (@(posedge pclk) disable iff (!presetn) // see R17
		$rose(ident_reg[SCSI_B_PE]) |-> ident_reg[SCSI_B_TC] || ident_reg[SCSI_B_RC])
		else $error("parity flag without char flag");
	a_vok_err: assert property (@(posedge pclk) disable iff (!presetn) // see R13
		vok_fall |=> ident_reg[SCSI_B_VOK])
		else $error("supply error not latched");
	a_contact_guard: assert property (@(posedge pclk) disable iff (!presetn) // see R07
		!supply_in_range_status |=> $stable(contact_reg & SCSI_CONTACT_GUARDED))
		else $error("contact bit changed without good supply");
	a_irq_line: assert property (@(posedge pclk) disable iff (!presetn) // see R21
		irq == |((ident_reg | {1'b0, card_irq_reg, 6'h00}) & enable_reg))
		else $error("irq line mismatch");
	a_card_irq: assert property (@(posedge pclk) disable iff (!presetn) // see R04
		card_rise && enable_reg[SCSI_B_CARD] |=> irq)
		else $error("presence rise gave no irq");
	a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn) // see R05
		rd && idx == SCSI_IDX_ENABLE |-> prdata[5] == 1'b0)
		else $error("reserved enable bit read nonzero");
	a_tbe_irq: assert property (@(posedge pclk) disable iff (!presetn) // see R12
		tx_buffer_moved |=> ident_reg[SCSI_B_TBE])
		else $error("buffer empty flag not latched");
	a_wto_irq: assert property (@(posedge pclk) disable iff (!presetn) // see R14
		wait_expired |=> ident_reg[SCSI_B_WTO] && wait_timeout_status)
		else $error("timeout flag not latched");
	a_rx_fail: assert property (@(posedge pclk) disable iff (!presetn) // see R10
		rx_char_failed |=> rx_char_done_status && ident_reg[SCSI_B_RC])
		else $error("failed reception not reported");
	a_pe_norep: assert property (@(posedge pclk) disable iff (!presetn) // see R11
		!rep_on && !rx_char_failed && !parity_error_status |=> !parity_error_status)
		else $error("parity error set without failed reception");
	a_ident_rsvd: assert property (@(posedge pclk) disable iff (!presetn) // see R05
		rd && idx == SCSI_IDX_IDENT |-> prdata[6:5] == 2'b00)
		else $error("reserved ident bits read nonzero");
endmodule : scsi_status_irq

// file: rtl/scsi_pkg.sv
/*
 * scsi_pkg: register map, field positions, reset values and sizes for the smart card
 * status and interrupt block.
 * Assumes an APB slave with 32-bit data; every register sits in its own aligned word.
 */
package scsi_pkg;
	// printed offsets are not all multiples of four: they are indices, byte address = 4 x index
	localparam logic [7:0] SCSI_IDX_SELECT = 8'hFA; // repetition select register
	localparam logic [7:0] SCSI_IDX_ENABLE = 8'hFB;
	localparam logic [7:0] SCSI_IDX_IDENT = 8'hFC;
	localparam logic [7:0] SCSI_IDX_STATUS = 8'hFD;
	localparam logic [7:0] SCSI_IDX_CONTACT = 8'hFE;
	localparam logic [7:0] SCSI_IDX_CONTROL = 8'hFF;
	localparam logic [7:0] SCSI_IDX_BUFFER = 8'hF9; // transmit/receive byte buffer
	localparam int SCSI_ADDR_W = 12;
	localparam int SCSI_IDX_LSB = 2;
	// status bits
	localparam int SCSI_B_TBE = 7;
	localparam int SCSI_B_CARD = 6;
	localparam int SCSI_B_VOK = 4;
	localparam int SCSI_B_WTO = 3;
	localparam int SCSI_B_TC = 2;
	localparam int SCSI_B_RC = 1;
	localparam int SCSI_B_PE = 0;
	// control register fields
	localparam int SCSI_B_CARDDET = 6;
	localparam int SCSI_B_VSEL_LO = 4;
	localparam int SCSI_B_CREP = 1;
	// select register field
	localparam int SCSI_B_REPSEL = 4;
	// contact register: c8, c4, io, clk, rst
	localparam logic [7:0] SCSI_CONTACT_GUARDED = 8'h3E;
	localparam logic [7:0] SCSI_CONTACT_RW = 8'hBF;
	// writable and readable masks
	localparam logic [7:0] SCSI_ENABLE_MASK = 8'hDF;
	localparam logic [7:0] SCSI_IDENT_MASK = 8'h9F;
	localparam logic [7:0] SCSI_STATUS_SWCLR = 8'h07;
	localparam logic [7:0] SCSI_SELECT_MASK = 8'h58;
	localparam logic [7:0] SCSI_STATUS_RESET = 8'h80;
	localparam logic [7:0] SCSI_ZERO8 = 8'h00;
	localparam logic [2:0] SCSI_REP_NORMAL = 3'h5; // 1 + 4 repeats
	localparam logic [2:0] SCSI_REP_SHORT = 3'h4; // 1 + 3 repeats
endpackage : scsi_pkg

// file: test/scsi_card_model.sv
/*
 * scsi_card_model: card side of the status block: presence and supply pins plus
 * UART and waiting time event pulses. Assumes pclk from the bench, which calls the tasks.
 */
`timescale 1ns/1ps
module scsi_card_model (
	input wire logic pclk,
	output logic card_detect_pin,
	output logic supply_in_range_pin,
	output logic [6:0] ev,
	output logic [7:0] rx_byte
);
	// pins idle with no card and no supply; events quiet
	initial begin
		card_detect_pin = 1'b1;
		supply_in_range_pin = 1'b0;
		ev = 7'h00;
		rx_byte = 8'h5A;
	end
	// one-cycle event pulse, k picks the source; a fresh byte stands with it until the next
	task fire(input int k);
		@(posedge pclk);
		ev[k] <= 1'b1;
		rx_byte <= 8'($urandom);
		@(posedge pclk);
		ev <= 7'h00;
	endtask : fire
	// presence switch is open with no card, so the pin goes low on insertion
	task insert(input logic on);
		@(posedge pclk);
		card_detect_pin <= ~on;
	endtask : insert
	task supply(input logic on);
		@(posedge pclk);
		supply_in_range_pin <= on;
	endtask : supply
endmodule : scsi_card_model

// file: test/test_smart_card_status_irq.sv
/*
 * test_smart_card_status_irq: self-checking bench for scsi_status_irq.
 * Assumes a zero wait state APB slave and the card model driving the far side.
 */
`timescale 1ns/1ps
module test_smart_card_status_irq;
	import scsi_pkg::*;
	`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
		$display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, irq, tx_byte_load, cdp, sip;
	logic [7:0] tx_byte, rx_byte, en_e, id_e, r, cl, cb, exp_b;
	logic [33:0] exp_w;
	logic [3:0] strb = 4'hF;
	logic [6:0] ev;
	logic [2:0] repeat_total;
	logic [33:0] expq[$];
	logic [7:0] txq[$];
	int err_total = 0;
	int n_checks = 0;
	int ks[4] = '{0, 1, 3, 5};
	int bs[4] = '{7, 2, 1, 3};
	always #25 pclk = ~pclk;
	scsi_status_irq DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .card_detect_pin(cdp),
		.supply_in_range_pin(sip), .tx_buffer_moved(ev[0]), .tx_char_ok(ev[1]),
		.tx_char_failed(ev[2]), .rx_char_ok(ev[3]), .rx_char_failed(ev[4]),
		.wait_expired(ev[5]), .wait_reload(ev[6]), .rx_byte(rx_byte), .tx_byte(tx_byte),
		.tx_byte_load(tx_byte_load), .contact_levels(cl), .control_bits(cb),
		.repeat_total(repeat_total), .irq(irq));
	scsi_card_model card (.pclk(pclk), .card_detect_pin(cdp), .supply_in_range_pin(sip),
		.ev(ev), .rx_byte(rx_byte));
	// watcher: each completed read or byte load takes the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			exp_w = expq.pop_front();
			`CHK({irq, pslverr, prdata}, exp_w)
		end
		if (tx_byte_load === 1'b1) begin
			exp_b = txq.pop_front();
			`CHK(tx_byte, exp_b)
		end
	end
	// one APB transfer, held until pready is seen high
	task xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, {24'($urandom), d});
	endtask : wr
	// expected irq follows from the flags and enables the bench believes are set
	task rd(input logic [7:0] idx, input logic [7:0] d);
		expq.push_back({|(en_e & id_e), 1'b0, 24'h000000, d});
		xfer(1'b0, idx, 32'h00000000);
	endtask : rd
	task results;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results
	// the tests need well under a thousand cycles; far beyond that counts as a hang
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		results();
	end
	// main sequence
	initial begin
		en_e = 8'h00;
		id_e = 8'h00;
		void'($urandom(32'h010E));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(SCSI_IDX_STATUS, SCSI_STATUS_RESET);
		rd(SCSI_IDX_IDENT, 8'h00);
		expq.push_back({2'b01, 32'h00000000});
		xfer(1'b0, 8'h10, 32'h00000000);
		$display("reset test done");
		repeat (4) begin
			r = 8'($urandom);
			en_e = r & SCSI_ENABLE_MASK;
			wr(SCSI_IDX_ENABLE, r);
			rd(SCSI_IDX_ENABLE, en_e);
		end
		en_e = 8'h00;
		wr(SCSI_IDX_ENABLE, 8'h00);
		// a write without its low byte lane is refused
		strb <= {3'($urandom), 1'b0};
		wr(SCSI_IDX_ENABLE, 8'hFF);
		strb <= 4'hF;
		rd(SCSI_IDX_ENABLE, 8'h00);
		$display("enable test done");
		for (int i = 0; i < 4; i++) begin
			card.fire(ks[i]);
			id_e = 8'h00;
			id_e[bs[i]] = 1'b1;
			rd(SCSI_IDX_IDENT, id_e);
			en_e = id_e;
			wr(SCSI_IDX_ENABLE, en_e);
			rd(SCSI_IDX_IDENT, id_e);
			wr(SCSI_IDX_IDENT, id_e);
			id_e = 8'h00;
			rd(SCSI_IDX_IDENT, 8'h00);
			en_e = 8'h00;
			wr(SCSI_IDX_ENABLE, 8'h00);
		end
		rd(SCSI_IDX_STATUS, 8'h8E);
		wr(SCSI_IDX_STATUS, 8'h00);
		rd(SCSI_IDX_STATUS, 8'h88);
		card.fire(6);
		rd(SCSI_IDX_STATUS, 8'h80);
		// repetition on: a failed final send raises parity but not done
		wr(SCSI_IDX_CONTROL, 8'h02);
		card.fire(2);
		`CHK(cb, 8'h02)
		id_e = 8'h05;
		en_e = 8'h05;
		wr(SCSI_IDX_ENABLE, en_e);
		rd(SCSI_IDX_STATUS, 8'h81);
		rd(SCSI_IDX_IDENT, 8'h05);
		wr(SCSI_IDX_CONTROL, 8'h00);
		card.fire(2);
		rd(SCSI_IDX_STATUS, 8'h85);
		wr(SCSI_IDX_STATUS, 8'h00);
		wr(SCSI_IDX_IDENT, 8'hFF);
		card.fire(4);
		id_e = 8'h03;
		en_e = 8'h01;
		wr(SCSI_IDX_ENABLE, en_e);
		rd(SCSI_IDX_STATUS, 8'h83);
		rd(SCSI_IDX_IDENT, 8'h03);
		rd(SCSI_IDX_BUFFER, rx_byte);
		wr(SCSI_IDX_IDENT, 8'hFF);
		wr(SCSI_IDX_STATUS, 8'h00);
		id_e = 8'h00;
		$display("event test done");
		// byte handed to the UART; software waits on buffer-empty with a short guard time
		r = 8'($urandom);
		txq.push_back(r);
		wr(SCSI_IDX_BUFFER, r);
		rd(SCSI_IDX_STATUS, 8'h00);
		card.fire(0);
		id_e = 8'h80;
		rd(SCSI_IDX_STATUS, 8'h80);
		wr(SCSI_IDX_IDENT, 8'hFF);
		wr(SCSI_IDX_IDENT, 8'h40);
		id_e = 8'h00;
		$display("buffer test done");
		// presence enable set first, so the rise itself must raise the line
		en_e = 8'h40;
		wr(SCSI_IDX_ENABLE, en_e);
		card.insert(1'b1);
		repeat (4) @(posedge pclk);
		id_e = 8'h40;
		rd(SCSI_IDX_STATUS, 8'hC0);
		rd(SCSI_IDX_IDENT, 8'h00);
		wr(SCSI_IDX_IDENT, 8'h40);
		id_e = 8'h00;
		card.insert(1'b0);
		repeat (4) @(posedge pclk);
		rd(SCSI_IDX_STATUS, 8'h80);
		$display("presence test done");
		wr(SCSI_IDX_CONTACT, 8'hFF);
		rd(SCSI_IDX_CONTACT, 8'h81);
		`CHK(cl, 8'h81)
		card.supply(1'b1);
		repeat (4) @(posedge pclk);
		rd(SCSI_IDX_STATUS, 8'h90);
		wr(SCSI_IDX_CONTACT, 8'hFF);
		rd(SCSI_IDX_CONTACT, 8'hBF);
		`CHK(cl, 8'hBF)
		en_e = 8'h10;
		wr(SCSI_IDX_ENABLE, en_e);
		card.supply(1'b0);
		repeat (4) @(posedge pclk);
		id_e = 8'h10;
		rd(SCSI_IDX_IDENT, 8'h10);
		$display("supply test done");
		`CHK(repeat_total, SCSI_REP_NORMAL)
		wr(SCSI_IDX_SELECT, 8'hFF);
		@(negedge pclk);
		`CHK(repeat_total, SCSI_REP_SHORT)
		rd(SCSI_IDX_SELECT, SCSI_SELECT_MASK);
		$display("select test done");
		repeat (2) @(posedge pclk);
		results();
	end
endmodule : test_smart_card_status_irq
